// File: rtl/cmpe_comparator_edge_control.sv
/*
 * comparator control and status register with edge flags.
 * assumes the processor bus gives address, page, write and read strobes
 * for one cycle each, and the comparator result is asynchronous to CLK.
 */
`default_nettype none

// What this block does
// RULE1 - result bit six shows current comparator output
// RULE2 - low-to-high result sets rise flag bit five
// RULE3 - rise flag held until software writes zero
// RULE4 - high-to-low result sets fall flag bit four
// RULE5 - fall flag held until software writes zero
// RULE6 - bits three:two drive positive hysteresis code
// RULE7 - bits one:zero drive negative hysteresis code
// RULE8 - enable bit seven; synchronise result; disabled: no flags (disabled, edges set no flag, but a write still sets either flag)
module cmpe_comparator_edge_control
    import cmpe_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_PAGE,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic CMP_RESULT,
    output cmpe_analog_t ANALOG_CTRL
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    // true when the bus names this register on its page
    function automatic logic csr_hit(input logic [7:0] addr,
                                     input logic [7:0] page);
        csr_hit = (addr == CMPE_CSR_ADDR) && (page == CMPE_CSR_PAGE);
    endfunction

    cmpe_state_t st_reg; // registered state
    cmpe_state_t st_next; // next state
    logic wr_hit; // write to this register this cycle
    logic rd_hit; // read of this register this cycle
    logic rise_seen; // synchronised result went high
    logic fall_seen; // synchronised result went low

    assign wr_hit = SFR_WR && csr_hit(SFR_ADDR, SFR_PAGE);
    assign rd_hit = SFR_RD && csr_hit(SFR_ADDR, SFR_PAGE);

    ////////////////////////////////////////////////////////////////////////
    // next state

    // edges are taken only from the second sync stage, never the first
    assign rise_seen = st_reg.sync_second && !st_reg.result_prev;
    assign fall_seen = !st_reg.sync_second && st_reg.result_prev;

    // one process builds the whole next state
    always_comb begin
        st_next = st_reg;
        // two-stage synchroniser on the asynchronous result
        st_next.sync_first = CMP_RESULT; // see RULE8
        st_next.sync_second = st_reg.sync_first; // see RULE8
        st_next.result_prev = st_reg.sync_second;
        // software write stores every writable field
        if (wr_hit) begin
            st_next.ctrl.enable = SFR_WDATA[CMPE_ENABLE_BIT]; // see RULE8
            st_next.ctrl.pos_hysteresis_select =
                SFR_WDATA[CMPE_POS_HI:CMPE_POS_LO]; // see RULE6
            st_next.ctrl.neg_hysteresis_select =
                SFR_WDATA[CMPE_NEG_HI:CMPE_NEG_LO]; // see RULE7
            st_next.rise_event_flag = SFR_WDATA[CMPE_RISE_BIT]; // see RULE3
            st_next.fall_event_flag = SFR_WDATA[CMPE_FALL_BIT]; // see RULE5
        end
        // limitation: edge history clears on reset, so a pin already high
        // looks like one rise; enable is 0 then unless written at once
        // an edge in the clearing cycle wins, so no event is lost
        if (st_reg.ctrl.enable && rise_seen) begin
            st_next.rise_event_flag = 1'b1; // see RULE2
        end
        if (st_reg.ctrl.enable && fall_seen) begin
            st_next.fall_event_flag = 1'b1; // see RULE4
        end
        // read data is registered; unmapped or idle reads return zero
        st_next.rdata = 8'h00;
        if (rd_hit) begin
            st_next.rdata = {st_reg.ctrl.enable,
                             st_reg.sync_second, // see RULE1
                             st_reg.rise_event_flag,
                             st_reg.fall_event_flag,
                             st_reg.ctrl.pos_hysteresis_select,
                             st_reg.ctrl.neg_hysteresis_select};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // everything clears on reset; the comparator starts disabled
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign SFR_RDATA = st_reg.rdata;
    assign ANALOG_CTRL = st_reg.ctrl; // see RULE6

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // a write that clears the rise flag
    sequence rise_clear_s;
        wr_hit && !SFR_WDATA[CMPE_RISE_BIT];
    endsequence

    // a write that clears the fall flag
    sequence fall_clear_s;
        wr_hit && !SFR_WDATA[CMPE_FALL_BIT];
    endsequence

    // pin level reaches the second stage after two edges
    sequence pin_high_s;
        CMP_RESULT ##1 st_reg.sync_first;
    endsequence

    rise_sets_a: assert property ( // see RULE2
        st_reg.ctrl.enable && $rose(st_reg.sync_second)
        |=> st_reg.rise_event_flag)
        else $error("rise flag not set after rising result");

    fall_sets_a: assert property ( // see RULE4
        st_reg.ctrl.enable && $fell(st_reg.sync_second)
        |=> st_reg.fall_event_flag)
        else $error("fall flag not set after falling result");

    rise_holds_a: assert property ( // see RULE3
        st_reg.rise_event_flag
        && !(wr_hit && !SFR_WDATA[CMPE_RISE_BIT])
        |=> st_reg.rise_event_flag)
        else $error("rise flag dropped without software clear");

    fall_holds_a: assert property ( // see RULE5
        st_reg.fall_event_flag
        && !(wr_hit && !SFR_WDATA[CMPE_FALL_BIT])
        |=> st_reg.fall_event_flag)
        else $error("fall flag dropped without software clear");

    // a clear with no edge in the same cycle really lowers the flag
    rise_clears_a: assert property ( // see RULE3
        rise_clear_s ##0 !(st_reg.ctrl.enable && rise_seen)
        |=> !st_reg.rise_event_flag)
        else $error("rise flag not cleared by software write");

    // the same for the fall flag
    fall_clears_a: assert property ( // see RULE5
        fall_clear_s ##0 !(st_reg.ctrl.enable && fall_seen)
        |=> !st_reg.fall_event_flag)
        else $error("fall flag not cleared by software write");

    // an edge in the clearing cycle keeps the flag set
    rise_wins_a: assert property ( // see RULE3
        rise_clear_s ##0 (st_reg.ctrl.enable && rise_seen)
        |=> st_reg.rise_event_flag)
        else $error("clearing write hid a rising edge");

    disabled_quiet_a: assert property ( // see RULE8
        !st_reg.ctrl.enable && !st_reg.rise_event_flag
        && !st_reg.fall_event_flag && !wr_hit
        |=> !st_reg.rise_event_flag && !st_reg.fall_event_flag)
        else $error("flag set while comparator disabled");

    sync_delay_a: assert property ( // see RULE8
        pin_high_s |=> st_reg.sync_second)
        else $error("result not through two sync stages");

    // any change at the second stage is the pin two edges earlier
    sync_lag_a: assert property ( // see RULE8
        $changed(st_reg.sync_second)
        |-> st_reg.sync_second == $past(CMP_RESULT, 2))
        else $error("result not delayed by exactly two stages");

    result_read_a: assert property ( // see RULE1
        rd_hit |=> SFR_RDATA[CMPE_RESULT_BIT] == $past(st_reg.sync_second))
        else $error("read result bit does not match comparator");

    // both sticky flags show in the read image
    flags_read_a: assert property ( // see RULE2 RULE4
        rd_hit |=>
            SFR_RDATA[CMPE_RISE_BIT] == $past(st_reg.rise_event_flag)
            && SFR_RDATA[CMPE_FALL_BIT] == $past(st_reg.fall_event_flag))
        else $error("read flag bits do not match the flags");

    pos_hyst_a: assert property ( // see RULE6
        wr_hit |=> ANALOG_CTRL.pos_hysteresis_select
                   == $past(SFR_WDATA[CMPE_POS_HI:CMPE_POS_LO]))
        else $error("positive hysteresis not taken from write");

    neg_hyst_a: assert property ( // see RULE7
        wr_hit |=> ANALOG_CTRL.neg_hysteresis_select
                   == $past(SFR_WDATA[CMPE_NEG_HI:CMPE_NEG_LO]))
        else $error("negative hysteresis not taken from write");

    // the enable bit reaches the analog side one cycle after a write
    enable_write_a: assert property ( // see RULE8
        wr_hit |=> ANALOG_CTRL.enable == $past(SFR_WDATA[CMPE_ENABLE_BIT]))
        else $error("enable not taken from write");

    unmapped_zero_a: assert property (
        !rd_hit |=> SFR_RDATA == 8'h00)
        else $error("read data not zero without register read");

endmodule

`default_nettype wire

// File: rtl/cmpe_pkg.sv
/*
 * constants and carrier types for the comparator edge control block.
 * assumes an 8-bit special-function-register bus with page select and
 * an analog comparator front end outside this block.
 */
`default_nettype none

package cmpe_pkg;

    // register location on the special-function-register bus
    localparam logic [7:0] CMPE_CSR_ADDR = 8'h9A;
    localparam logic [7:0] CMPE_CSR_PAGE = 8'h10;
    localparam logic [7:0] CMPE_CSR_RESET = 8'h00;

    // bit positions inside comparator_control_status
    localparam int CMPE_ENABLE_BIT = 7;
    localparam int CMPE_RESULT_BIT = 6;
    localparam int CMPE_RISE_BIT = 5;
    localparam int CMPE_FALL_BIT = 4;
    localparam int CMPE_POS_HI = 3;
    localparam int CMPE_POS_LO = 2;
    localparam int CMPE_NEG_HI = 1;
    localparam int CMPE_NEG_LO = 0;

    // hysteresis codes: off, 5 mV, 10 mV, 20 mV
    localparam logic [1:0] CMPE_HYST_OFF = 2'h0;
    localparam logic [1:0] CMPE_HYST_5MV = 2'h1;
    localparam logic [1:0] CMPE_HYST_10MV = 2'h2;
    localparam logic [1:0] CMPE_HYST_20MV = 2'h3;

    // settings that go to the analog comparator
    typedef struct packed {
        logic enable;
        logic [1:0] pos_hysteresis_select;
        logic [1:0] neg_hysteresis_select;
    } cmpe_analog_t;

    // whole state of the block
    typedef struct packed {
        cmpe_analog_t ctrl;
        logic rise_event_flag;
        logic fall_event_flag;
        logic sync_first;
        logic sync_second;
        logic result_prev;
        logic [7:0] rdata;
    } cmpe_state_t;

endpackage

`default_nettype wire

// File: tb/cmpe_front_model.sv
/*
 * behavioural model of the analog comparator front end.
 * assumes the bench sets the sign of the input difference on lvl.
 */
`default_nettype none

module cmpe_front_model
    import cmpe_pkg::*;
(
    input wire cmpe_analog_t ctrl,
    input wire logic lvl,
    output logic result
);
    timeunit 1ns;
    timeprecision 1ps;
    // output settles after the swing, unrelated to the clock edge
    assign #1 result = lvl;
endmodule

`default_nettype wire

// File: tb/comparator_edge_control_test.sv
/*
 * self-checking bench for the comparator edge control register.
 * assumes one clock, register at its package address and page.
 */
`default_nettype none

module comparator_edge_control_test
    import cmpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, cmp, lvl;
    logic [7:0] addr, page, wdata, rdata;
    cmpe_analog_t actl;
    int n_errors, samples_checked;
    cmpe_comparator_edge_control cmpe_comparator_edge_control_i (
        .CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_PAGE(page),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .CMP_RESULT(cmp), .ANALOG_CTRL(actl));
    cmpe_front_model cmpe_front_model_i (
        .ctrl(actl), .lvl(lvl), .result(cmp));
    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one strobe cycle; inputs move on the falling edge only
    task automatic acc(input logic w, r, input logic [7:0] a, p, d);
        @(negedge clk);
        {wr, rd, addr, page, wdata} = {w, r, a, p, d};
        @(negedge clk);
        {wr, rd} = 2'b00;
    endtask
    task automatic wr_csr(input logic [7:0] d);
        acc(1'b1, 1'b0, CMPE_CSR_ADDR, CMPE_CSR_PAGE, d);
    endtask
    // read data stands for one cycle only, so it is sampled right away
    task automatic rd_chk(input string what, input logic [7:0] exp);
        acc(1'b0, 1'b1, CMPE_CSR_ADDR, CMPE_CSR_PAGE, 8'h00);
        check(what, rdata, exp);
    endtask
    // swing long enough to cross the two-flop synchroniser
    task automatic swing(input logic v);
        @(negedge clk);
        lvl = v;
        repeat (4) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("reset image", CMPE_CSR_RESET);
        check("reset ctrl", {3'h0, actl}, 8'h00);
    endtask
    // every hysteresis code on both fields; bit six write is ignored
    task automatic t_hyst();
        logic [7:0] img;
        for (int i = 0; i < 4; i++) begin
            img = {4'h0, 2'(i), 2'(3 - i)};
            wr_csr({4'h4, 2'(i), 2'(3 - i)});
            check("hyst ctrl", {3'h0, actl}, img);
            rd_chk("hyst image", img);
        end
    endtask
    task automatic t_edges();
        wr_csr(8'h86);
        check("on ctrl", {3'h0, actl}, 8'h16);
        swing(1'b1);
        rd_chk("rise", 8'hE6);
        swing(1'b0);
        rd_chk("fall", 8'hB6);
        repeat (20) @(negedge clk);
        rd_chk("sticky", 8'hB6);
        wr_csr(8'h86);
        rd_chk("cleared", 8'h86);
    endtask
    // disabled: result still tracks, flags stay clear
    task automatic t_off();
        wr_csr(8'h00);
        check("off ctrl", {3'h0, actl}, 8'h00);
        swing(1'b1);
        rd_chk("off high", 8'h40);
        swing(1'b0);
        rd_chk("off low", 8'h00);
    endtask
    // a clearing write taken on the edge's own cycle loses to the edge
    task automatic t_race();
        wr_csr(8'h80);
        @(negedge clk);
        lvl = 1'b1;
        @(negedge clk);
        // this write is taken on the edge that sets the rise flag
        acc(1'b1, 1'b0, CMPE_CSR_ADDR, CMPE_CSR_PAGE, 8'h80);
        rd_chk("set wins", 8'hE0);
        wr_csr(8'h90);
        rd_chk("flag by write", 8'hD0);
        // read and write together: the read shows the old image
        acc(1'b1, 1'b1, CMPE_CSR_ADDR, CMPE_CSR_PAGE, 8'h00);
        check("read beside write", rdata, 8'hD0);
        rd_chk("after both", 8'h40);
        swing(1'b0);
    endtask
    // wrong address or page neither writes nor answers
    task automatic t_unmapped();
        wr_csr(8'h0F);
        acc(1'b1, 1'b0, 8'h9B, CMPE_CSR_PAGE, 8'hFF);
        acc(1'b1, 1'b0, CMPE_CSR_ADDR, 8'h00, 8'hFF);
        acc(1'b0, 1'b1, CMPE_CSR_ADDR, 8'h00, 8'h00);
        check("other page read", rdata, 8'h00);
        acc(1'b0, 1'b1, 8'h9B, CMPE_CSR_PAGE, 8'h00);
        check("other addr read", rdata, 8'h00);
        rd_chk("unchanged", 8'h0F);
        @(negedge clk);
        check("idle read data", rdata, 8'h00);
    endtask
    // reset in mid-run clears the enable bit, both flags and both hysteresis fields
    task automatic t_midreset();
        wr_csr(8'hBF);
        check("pre reset ctrl", {3'h0, actl}, 8'h1F);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd_chk("mid reset image", CMPE_CSR_RESET);
        check("mid reset ctrl", {3'h0, actl}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog against a hung run
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {rst, wr, rd, lvl, addr, page, wdata} = {1'b1, 27'h0};
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_hyst();
        t_edges();
        t_off();
        t_race();
        t_unmapped();
        t_midreset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
